// ===== verilog/pwm_fine_edge_registers.sv
/*
 * Fine-edge register bank of a pulse-width modulator, reached over APB.
 * Holds fine compare A, fine phase and fine period with alias locations,
 * and the control fields that steer the edge positioner.
 * Assumes the time-base zero and period events arrive as pclk pulses.
 */
//
// Functional notes
// - Compare fine count in bits 15-8.
// - Phase fine offset in bits 15-8.
// - Period fine 8 bits, any value.
// - Period fine ignores period load mode.
// - Period fine writes and reads use shadow.
// - Period fine reaches period_fine_applied only when enabled.
// - Both compare locations update same fine.
// - Compare alias writes shadowed per select bit.
// - All fields reset zero; reserved bytes read-only.
// - Shadow loads on zero, period, or either.
// - Edge select: off, rising, falling, both.
// - Source select: compare/period or phase.
`timescale 1ns/10ps
module pwm_fine_edge_registers (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        counter_zero,
	input  wire logic        counter_period,
	output logic      [7:0]  edge_fine_step,
	output logic      [1:0]  edge_select,
	output logic             edge_from_phase,
	output logic      [7:0]  period_fine_applied
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [7:0] control;
	logic [1:0] event_seen;
	logic [7:0] cmp_shadow;
	logic [7:0] cmp_active;
	logic [7:0] prd_shadow;
	logic [7:0] prd_active;
	logic [7:0] phase_fine;

	wire logic       wr;
	wire logic       rd;
	wire logic       hit_cmp;
	wire logic       hit_cmp_alias;
	wire logic       hit_phase;
	wire logic       hit_prd;
	wire logic       hit_prd_alias;
	wire logic       hit_ctl;
	wire logic       hit_status;
	wire logic       hit_event;
	wire logic       mapped;
	wire logic [7:0] wr_fine;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr            = psel && penable && pwrite;
	assign rd            = psel && penable && !pwrite;
	assign hit_cmp       = hit(paddr, fine_edge_pkg::off_compare_a_fine);
	assign hit_cmp_alias = hit(paddr, fine_edge_pkg::off_compare_a_fine_alias);
	assign hit_phase     = hit(paddr, fine_edge_pkg::off_phase_fine);
	assign hit_prd       = hit(paddr, fine_edge_pkg::off_period_fine);
	assign hit_prd_alias = hit(paddr, fine_edge_pkg::off_period_fine_alias);
	assign hit_ctl       = hit(paddr, fine_edge_pkg::off_fine_control);
	assign hit_status    = hit(paddr, fine_edge_pkg::off_fine_status);
	assign hit_event     = hit(paddr, fine_edge_pkg::off_timebase_event);
	assign mapped        = hit_cmp | hit_cmp_alias | hit_phase | hit_prd | hit_prd_alias |
		hit_ctl | hit_status | hit_event;
	// Fine byte sits in bits 15-8.
	assign wr_fine = pwdata[fine_edge_pkg::fine_msb:fine_edge_pkg::fine_lsb];

	// Every register answers at once, so no wait state is ever inserted.
	assign pready  = 1'b1;
	// An unmapped address flags an error; its write is dropped and its read is zero.
	assign pslverr = psel && penable && !mapped;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire logic [1:0] load_code;
	wire logic       cmp_immediate;
	wire logic       period_enable;
	wire logic       load_now;

	assign load_code     = control[fine_edge_pkg::ctl_load_lsb +: 2];
	assign cmp_immediate = control[fine_edge_pkg::ctl_shadow_bit];
	assign period_enable = control[fine_edge_pkg::ctl_period_en_bit];

	assign load_now =
		(load_code == fine_edge_pkg::load_on_zero)   ? counter_zero :
		(load_code == fine_edge_pkg::load_on_period) ? counter_period :
		(load_code == fine_edge_pkg::load_on_either) ? (counter_zero | counter_period) :
		1'b0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control <= fine_edge_pkg::control_reset;
		end
		else if (wr && hit_ctl)
		begin
			control <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Fine compare A, shared by primary and alias
	// ------------------------------------------------------------
	wire logic cmp_write;

	// Either location writes the same fine part.
	// One storage element behind both addresses.
	assign cmp_write = wr && (hit_cmp || hit_cmp_alias);

	// Shadowing follows the compare shadow select.
	fine_shadow_slot compare_slot (
		.pclk       (pclk),
		.presetn    (presetn),
		.write_en   (cmp_write),
		.write_data (wr_fine),
		.shadowed   (!cmp_immediate),
		.load_now   (load_now),
		.shadow     (cmp_shadow),
		.active     (cmp_active)
	);

	// ------------------------------------------------------------
	// Fine period, shared by primary and alias
	// ------------------------------------------------------------
	wire logic prd_write;

	// Full byte range accepted, no clipping.
	// Period primary and alias share storage.
	assign prd_write = wr && (hit_prd || hit_prd_alias);

	// Always shadowed, period load mode has no say.
	fine_shadow_slot period_slot (
		.pclk       (pclk),
		.presetn    (presetn),
		.write_en   (prd_write),
		.write_data (wr_fine),
		.shadowed   (1'b1),
		.load_now   (counter_zero),
		.shadow     (prd_shadow),
		.active     (prd_active)
	);

	// ------------------------------------------------------------
	// Fine phase and sticky time-base events
	// ------------------------------------------------------------
	wire logic [1:0] event_clear;
	wire logic [1:0] event_set;
	wire logic [1:0] next_event_seen;

	assign event_clear     = (wr && hit_event) ? pwdata[1:0] : 2'h0;
	assign event_set       = {counter_period, counter_zero};
	// Set wins over the write-one clear so no event is lost.
	assign next_event_seen = (event_seen & ~event_clear) | event_set;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_fine <= fine_edge_pkg::fine_reset;
			event_seen <= 2'h0;
		end
		else
		begin
			if (wr && hit_phase)
				phase_fine <= wr_fine;
			event_seen <= next_event_seen;
		end
	end

	// ------------------------------------------------------------
	// Edge positioner outputs
	// ------------------------------------------------------------
	logic [7:0] next_step;
	logic [7:0] next_applied;

	wire logic       source_phase;
	wire logic       period_mode;
	wire logic [1:0] edge_mode;
	wire logic [7:0] step_base;

	assign source_phase = control[fine_edge_pkg::ctl_source_bit];
	assign period_mode  = control[fine_edge_pkg::ctl_period_mode];
	assign edge_mode    = control[fine_edge_pkg::ctl_edge_lsb +: 2];

	assign step_base = period_mode ? prd_active : cmp_active;
	assign next_step = source_phase ? phase_fine : step_base;
	// Period fine reaches period_fine_applied only when enabled.
	assign next_applied = period_enable ? prd_active : 8'h00;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_fine_step      <= 8'h00;
			edge_select         <= 2'h0;
			edge_from_phase     <= 1'b0;
			period_fine_applied <= 8'h00;
		end
		else
		begin
			edge_fine_step      <= next_step;
			edge_select         <= edge_mode;
			edge_from_phase     <= source_phase;
			period_fine_applied <= next_applied;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] read_mux;

	wire logic [31:0] word_cmp;
	wire logic [31:0] word_phase;
	wire logic [31:0] word_prd;
	wire logic [31:0] word_ctl;
	wire logic [31:0] word_status;
	wire logic [31:0] word_event;
	wire logic        read_setup;

	function automatic logic [31:0] fine_word(input logic [7:0] b);
		fine_word = {16'h0, b, 8'h00};
	endfunction

	assign word_cmp    = fine_word(cmp_shadow);
	assign word_phase  = fine_word(phase_fine);
	// Period read returns the shadow copy.
	assign word_prd    = fine_word(prd_shadow);
	assign word_ctl    = {24'h0, control};
	assign word_status = {16'h0, prd_active, cmp_active};
	assign word_event  = {30'h0, event_seen};

	// Alias locations fall through to zero; their readback is not meant to be used.
	assign read_mux =
		hit_cmp    ? word_cmp :
		hit_phase  ? word_phase :
		hit_prd    ? word_prd :
		hit_ctl    ? word_ctl :
		hit_status ? word_status :
		hit_event  ? word_event :
		32'h0;

	// Capturing in the setup cycle lets pready stay high with no wait state.
	assign read_setup = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (read_setup)
			prdata <= read_mux;
	end

endmodule

// ===== verilog/fine_edge_pkg.sv
/*
 * Constants for the fine-edge register bank: APB offsets, field positions,
 * reset values and the encodings of the load-event and edge-select fields.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package fine_edge_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] off_compare_a_fine       = 8'h00;
	localparam logic [7:0] off_phase_fine           = 8'h04;
	localparam logic [7:0] off_period_fine          = 8'h08;
	localparam logic [7:0] off_compare_a_fine_alias = 8'h0c;
	localparam logic [7:0] off_period_fine_alias    = 8'h10;
	localparam logic [7:0] off_fine_control         = 8'h14;
	localparam logic [7:0] off_fine_status          = 8'h18;
	localparam logic [7:0] off_timebase_event       = 8'h1c;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int fine_lsb           = 8;
	localparam int fine_msb           = 15;
	localparam int ctl_edge_lsb       = 0;
	localparam int ctl_source_bit     = 2;
	localparam int ctl_load_lsb       = 3;
	localparam int ctl_shadow_bit     = 5;
	localparam int ctl_period_en_bit  = 6;
	localparam int ctl_period_mode    = 7;
	localparam int evt_zero_bit       = 0;
	localparam int evt_period_bit     = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] fine_reset    = 8'h00;
	localparam logic [7:0] control_reset = 8'h00;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		load_on_zero,
		load_on_period,
		load_on_either,
		load_reserved
	} fine_load_event_e;

	typedef enum logic [1:0] {
		edge_disabled,
		edge_rising,
		edge_falling,
		edge_both
	} edge_select_e;

endpackage

// ===== verilog/fine_shadow_slot.sv
/*
 * One fine value with a shadow and an active copy.
 * Assumes the write strobe and load strobe are on pclk.
 */
`timescale 1ns/10ps
module fine_shadow_slot (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       write_en,
	input  wire logic [7:0] write_data,
	input  wire logic       shadowed,
	input  wire logic       load_now,
	output logic      [7:0] shadow,
	output logic      [7:0] active
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	wire logic [7:0] next_shadow;
	wire logic [7:0] next_active;

	assign next_shadow = write_en ? write_data : shadow;
	// A write in the same cycle as a load lands directly in active when immediate.
	assign next_active = (write_en && !shadowed) ? write_data :
		(load_now ? shadow : active);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shadow <= fine_edge_pkg::fine_reset;
			active <= fine_edge_pkg::fine_reset;
		end
		else
		begin
			shadow <= next_shadow;
			active <= next_active;
		end
	end

endmodule

// ===== test/pwm_fine_edge_asserts.sv
/* Assertions for the fine-edge register bank.
   Bound to the top module; watches its ports only. */
`timescale 1ns/10ps
module pwm_fine_edge_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        counter_zero,
	input wire logic        counter_period,
	input wire logic [7:0]  edge_fine_step,
	input wire logic [1:0]  edge_select,
	input wire logic        edge_from_phase,
	input wire logic [7:0]  period_fine_applied
);
	// Last values software wrote; outputs lag a write, so checks wait for them to settle.
	logic [7:0] ctl, ph, pd, cmp;
	wire        rd = psel && penable && !pwrite;
	wire        wr = psel && penable && pwrite && pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{ctl, ph, pd, cmp} <= 32'h0;
		else if (wr)
		begin
			if (paddr == 8'h14)
				ctl <= pwdata[7:0];
			if (paddr == 8'h04)
				ph <= pwdata[15:8];
			if (paddr == 8'h08 || paddr == 8'h10)
				pd <= pwdata[15:8];
			if (paddr == 8'h00 || paddr == 8'h0c)
				cmp <= pwdata[15:8];
		end
	end
	a_compare_read:
	assert property (rd && paddr == 8'h00 |-> prdata == {16'h0, cmp, 8'h00})
		else $error("compare read wrong");
	a_phase_read:
	assert property (rd && paddr == 8'h04 |-> prdata == {16'h0, ph, 8'h00})
		else $error("phase read wrong");
	a_period_shadow_read:
	assert property (rd && paddr == 8'h08 |-> prdata == {16'h0, pd, 8'h00})
		else $error("period read wrong");
	a_alias_read_zero:
	assert property (rd && (paddr == 8'h0c || paddr == 8'h10) |-> prdata == 32'h0)
		else $error("alias read not zero");
	a_reset_clear:
	assert property ($rose(presetn) |-> edge_fine_step == 8'h00
		&& period_fine_applied == 8'h00 && edge_select == 2'h0 && !edge_from_phase)
		else $error("outputs not clear after reset");
	a_applied_gated:
	assert property ((!ctl[6] && $stable(ctl))[*3] |-> period_fine_applied == 8'h00)
		else $error("period fine applied while disabled");
	a_edge_fields:
	assert property ($stable(ctl)[*3] |-> edge_select == ctl[1:0] && edge_from_phase == ctl[2])
		else $error("edge fields differ from control");
	a_phase_source:
	assert property ((ctl[2] && $stable(ctl) && $stable(ph))[*3] |-> edge_fine_step == ph)
		else $error("step not from phase");
endmodule

// ===== test/testbench.sv
/* Self-checking bench for the fine-edge register bank.
   Drives APB and the time-base event pulses itself. */
`timescale 1ns/10ps
module testbench;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        counter_zero = 1'b0, counter_period = 1'b0, pready, pslverr, edge_from_phase;
	logic [7:0]  paddr = 8'h00, edge_fine_step, period_fine_applied, a, old, s_cmp = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_data, v;
	logic [1:0]  edge_select;
	logic        rd_err;
	integer      seed = 59540;
	int          fails = 0, comparisons = 0, cycles = 0, i;

	always #2.5 pclk = ~pclk;

	pwm_fine_edge_registers uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .counter_zero, .counter_period, .edge_fine_step,
		.edge_select, .edge_from_phase, .period_fine_applied);

	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic pulse(input logic z, input logic p);
		@(posedge pclk);
		counter_zero <= z;
		counter_period <= p;
		@(posedge pclk);
		counter_zero <= 1'b0;
		counter_period <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	function automatic logic [31:0] fw(input logic [7:0] b);
		return {16'h0, b, 8'h00};
	endfunction

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// A hang is cut short well above the roughly 300 cycles the run needs.
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			summarize();
		end
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			chk("reset read", 32'h0, rd_data);
		end
		xfer(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, 32'(rd_err));
		chk("unmapped data", 32'h0, rd_data);
		for (i = 0; i < 24; i++)
		begin
			v = $random(seed);
			a = 8'(32'(v[18:16]) % 5 * 4);
			xfer(1'b1, a, v);
			if (a == 8'h00 || a == 8'h0c)
				s_cmp = v[15:8];
			xfer(1'b0, (a == 8'h0c) ? 8'h00 : (a == 8'h10) ? 8'h08 : a, 32'h0);
			chk("fine read", fw(v[15:8]), rd_data);
		end
		xfer(1'b1, 8'h14, 32'h40);
		xfer(1'b1, 8'h08, 32'h5a00);
		xfer(1'b0, 8'h18, 32'h0);
		chk("active before load", 32'h0, rd_data);
		chk("applied before load", 32'h0, 32'(period_fine_applied));
		pulse(1'b1, 1'b0);
		xfer(1'b0, 8'h18, 32'h0);
		chk("active after zero", {16'h0, 8'h5a, s_cmp}, rd_data);
		chk("applied enabled", 32'h5a, 32'(period_fine_applied));
		chk("step from compare", 32'(s_cmp), 32'(edge_fine_step));
		xfer(1'b1, 8'h14, 32'h80);
		repeat (3) @(posedge pclk);
		chk("applied disabled", 32'h0, 32'(period_fine_applied));
		chk("step from period", 32'h5a, 32'(edge_fine_step));
		for (i = 0; i < 3; i++)
		begin
			xfer(1'b1, 8'h14, 32'(i) << 3);
			old = s_cmp;
			s_cmp = ~old;
			xfer(1'b1, i[0] ? 8'h0c : 8'h00, fw(s_cmp));
			pulse(i == 1, i == 0);
			xfer(1'b0, 8'h18, 32'h0);
			chk("compare held", 32'(old), 32'(rd_data[7:0]));
			pulse(i != 1, i != 0);
			xfer(1'b0, 8'h18, 32'h0);
			chk("compare loaded", 32'(s_cmp), 32'(rd_data[7:0]));
		end
		xfer(1'b1, 8'h14, 32'h20);
		xfer(1'b1, 8'h0c, 32'h3c00);
		xfer(1'b0, 8'h18, 32'h0);
		chk("compare immediate", 32'h3c, 32'(rd_data[7:0]));
		chk("step immediate", 32'h3c, 32'(edge_fine_step));
		xfer(1'b1, 8'h04, 32'ha500);
		for (i = 0; i < 4; i++)
		begin
			xfer(1'b1, 8'h14, 32'(i) | 32'h4);
			repeat (3) @(posedge pclk);
			chk("edge select", 32'(i), 32'(edge_select));
			chk("phase step", 32'ha5, 32'(edge_fine_step));
		end
		summarize();
	end
endmodule

bind pwm_fine_edge_registers pwm_fine_edge_asserts asserts_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_zero,
	.counter_period, .edge_fine_step, .edge_select, .edge_from_phase, .period_fine_applied);
